// >>> src/sdp_pkg.sv
// Package with register map, field layout and timing constants of the divider control block.
package sdp_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_OFFSET_LOW   = 3'h0;
   localparam logic [2:0] ADDR_OFFSET_HIGH  = 3'h1;
   localparam logic [2:0] ADDR_PULL_RANGE   = 3'h2;
   localparam logic [2:0] ADDR_FB_INT_FRAC  = 3'h3;
   localparam logic [2:0] ADDR_FB_FRAC_LOW  = 3'h4;
   localparam logic [2:0] ADDR_FWD_DRIVE    = 3'h5;
   localparam logic [2:0] ADDR_DRIVE_MISC   = 3'h6;

   // ---------------------------------------------------------------
   // Field layout and masks
   // ---------------------------------------------------------------
   localparam int          FB_INT_W      = 5;
   localparam int          FB_FRAC_W     = 27;
   localparam int          FB_W          = 32;
   localparam int          FWD_W         = 13;
   localparam int          DRIVE_W       = 6;
   localparam int          OFFSET_W      = 26;
   localparam int          OFFSET_HIGH_W = 10;
   localparam int          RANGE_W       = 4;
   localparam int          OE_BIT        = 10;
   localparam logic [4:0]  FB_INT_MASK   = 5'h0E;
   localparam logic [12:0] FWD_MASK      = 13'h001B;
   localparam logic [15:0] REG_RESET     = 16'h0000;

   // Factory defaults, arbitrary plain values.
   localparam logic [3:0]  FACTORY_RANGE = 4'h0;

   // Full positive half of the offset word.
   localparam logic signed [25:0] OFFSET_FULL_POS = 26'h1FFFFFF;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS      = 4000;
   localparam int DISABLE_TIME_PS    = 2300000;
   localparam int SETTLE_TIME_PS     = 421000000;
   localparam int DISABLE_CYCLES     = DISABLE_TIME_PS / CLK_PERIOD_PS;
   localparam int SETTLE_CYCLES      = SETTLE_TIME_PS / CLK_PERIOD_PS;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [2:0]  addr;
      logic [15:0] wdata;
   } sdp_req_t;

   typedef struct packed {
      logic [FB_W-1:0]   feedback;
      logic [FWD_W-1:0]  forward;
      logic [DRIVE_W-1:0] drive;
   } sdp_synth_t;

   typedef enum logic [1:0] {
      ST_RUN    = 2'b00,
      ST_OFF    = 2'b01,
      ST_RELOCK = 2'b10
   } sdp_state_t;

endpackage

// >>> src/sdp_ctrl.sv
// Divider, drive and digital pull control registers with relock sequencing.
//
// Notes on behaviour
// - Feedback word: 5 integer, 27 fraction bits.
// - Integer part stored XORed with 01110b.
// - Forward divider 13 bits XORed with 0000000011011b.
// - feedback_int_frac_high holds integer, high fraction; feedback_frac_low low.
// - forward_div_drive_high forward divider, drive high; 0x06 low.
// - After forward_div_drive_high write, output off until locked; code also turns it back on SETTLE_CNT cycles after the write without lock.
// - Settling completes within 421 microseconds.
// - Pull shifts up to 3200 ppm, fine resolution.
// - Power-up uses factory frequency and pull range.
// - Offset limited to selected pull range.
// - Sixteen selectable pull ranges in a field.
// - Offset is 26-bit two's complement value.
// - Offset resets to zero, nominal frequency.
// - Offset low in 0x00, high in 0x01[9:0].
// - Low word held; high word starts change.
// - Pull range held in 0x02 bits 3:0.
// - Offset scales linearly; full word is range.
`timescale 1ns/10ps
module sdp_ctrl
   import sdp_pkg::*;
#(
   parameter int SETTLE_CNT = sdp_pkg::SETTLE_CYCLES
) (
   // Clock and reset
   input  wire logic                         core_clk_i,
   input  wire logic                         rst_i,
   // Register port from the serial slave
   input  wire sdp_pkg::sdp_req_t            req_i,
   output logic [15:0]                       rdata_o,
   output logic                              rvalid_o,
   // PLL side
   input  wire logic                         pll_lock_i,
   output sdp_pkg::sdp_synth_t               synth_o,
   output logic                              synth_load_o,
   // Digital pull
   output logic signed [25:0]                pull_offset_o,
   output logic [3:0]                        pull_range_o,
   output logic                              pull_update_o,
   // Output driver
   output logic                              clk_out_en_o,
   output logic                              soft_oe_o,
   output logic                              busy_o
);
   import sdp_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] zext_range(input logic [3:0] v);
      return {12'h000, v};
   endfunction

   // Strips the storage masks off the divider fields so the PLL sees the true N, M and drive.
   function automatic sdp_synth_t decode_synth(input logic [15:0] fb_hi,
                                               input logic [15:0] fb_lo,
                                               input logic [15:0] fwd,
                                               input logic [15:0] misc);
      sdp_synth_t s;
      s.feedback = {fb_hi[15:11] ^ FB_INT_MASK, fb_hi[10:0], fb_lo};
      s.forward  = fwd[15:3] ^ FWD_MASK;
      s.drive    = {fwd[2:0], misc[2:0]};
      return s;
   endfunction

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [15:0] offset_low, next_offset_low;
   logic [15:0] offset_high, next_offset_high;
   logic [15:0] range_reg, next_range_reg;
   logic [15:0] fb_high, next_fb_high;
   logic [15:0] fb_low, next_fb_low;
   logic [15:0] fwd_drive, next_fwd_drive;
   logic [15:0] drive_misc, next_drive_misc;
   logic [25:0] active_offset, next_active_offset;
   logic        pull_update, next_pull_update;
   logic        synth_load, next_synth_load;
   logic        lock_s1, lock_s2;
   logic        wr_fwd;

   assign wr_fwd = req_i.wr && (req_i.addr == ADDR_FWD_DRIVE);

   always_comb begin
      next_offset_low    = offset_low;
      next_offset_high   = offset_high;
      next_range_reg     = range_reg;
      next_fb_high       = fb_high;
      next_fb_low        = fb_low;
      next_fwd_drive     = fwd_drive;
      next_drive_misc    = drive_misc;
      next_active_offset = active_offset;
      next_pull_update   = 1'b0;
      next_synth_load    = 1'b0;
      if (req_i.wr) begin
         case (req_i.addr)
            ADDR_OFFSET_LOW: begin
               next_offset_low = req_i.wdata;
            end
            ADDR_OFFSET_HIGH: begin
               next_offset_high   = req_i.wdata;
               // The pair is committed only here so a half-written word never reaches the PLL.
               next_active_offset = {req_i.wdata[OFFSET_HIGH_W-1:0], offset_low};
               next_pull_update   = 1'b1;
            end
            ADDR_PULL_RANGE: begin
               next_range_reg = zext_range(req_i.wdata[RANGE_W-1:0]);
            end
            ADDR_FB_INT_FRAC: begin
               next_fb_high = req_i.wdata;
            end
            ADDR_FB_FRAC_LOW: begin
               next_fb_low = req_i.wdata;
            end
            ADDR_FWD_DRIVE: begin
               next_fwd_drive  = req_i.wdata;
               next_synth_load = 1'b1;
            end
            ADDR_DRIVE_MISC: begin
               next_drive_misc = req_i.wdata;
            end
            default: begin
               next_pull_update = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         offset_low    <= REG_RESET;
         offset_high   <= REG_RESET;
         range_reg     <= {12'h000, FACTORY_RANGE};
         fb_high       <= REG_RESET;
         fb_low        <= REG_RESET;
         fwd_drive     <= REG_RESET;
         drive_misc    <= REG_RESET;
         active_offset <= 26'h0000000;
         pull_update   <= 1'b0;
         synth_load    <= 1'b0;
      end else begin
         offset_low    <= next_offset_low;
         offset_high   <= next_offset_high;
         range_reg     <= next_range_reg;
         fb_high       <= next_fb_high;
         fb_low        <= next_fb_low;
         fwd_drive     <= next_fwd_drive;
         drive_misc    <= next_drive_misc;
         active_offset <= next_active_offset;
         pull_update   <= next_pull_update;
         synth_load    <= next_synth_load;
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   logic [15:0] rdata, next_rdata;
   logic        rvalid, next_rvalid;

   always_comb begin
      next_rvalid = req_i.rd;
      case (req_i.addr)
         ADDR_OFFSET_LOW:  next_rdata = offset_low;
         ADDR_OFFSET_HIGH: next_rdata = offset_high;
         ADDR_PULL_RANGE:  next_rdata = range_reg;
         ADDR_FB_INT_FRAC: next_rdata = fb_high;
         ADDR_FB_FRAC_LOW: next_rdata = fb_low;
         ADDR_FWD_DRIVE:   next_rdata = fwd_drive;
         ADDR_DRIVE_MISC:  next_rdata = drive_misc;
         default:          next_rdata = 16'h0000;
      endcase
      if (!req_i.rd) begin
         next_rdata = rdata;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata  <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         rdata  <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // ---------------------------------------------------------------
   // Decoding of the divider words
   // ---------------------------------------------------------------
   sdp_synth_t synth, next_synth;

   // An all-zero register file decodes to the default dividers.
   localparam sdp_synth_t SYNTH_RESET = decode_synth(REG_RESET, REG_RESET, REG_RESET, REG_RESET);

   // Decoding from the next values keeps the PLL word in step with the register write
   // while still launching it from a flip-flop.
   always_comb begin
      next_synth = decode_synth(next_fb_high, next_fb_low, next_fwd_drive, next_drive_misc);
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         synth <= SYNTH_RESET;
      end else begin
         synth <= next_synth;
      end
   end

   // ---------------------------------------------------------------
   // Relock sequencing
   // ---------------------------------------------------------------
   // Lock comes from the analog PLL, so it is synchronised first.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
      end else begin
         lock_s1 <= pll_lock_i;
         lock_s2 <= lock_s1;
      end
   end

   sdp_state_t  state, next_state;
   logic [31:0] tmr, next_tmr;
   logic        out_en, next_out_en;

   always_comb begin
      next_state  = state;
      next_tmr    = tmr;
      next_out_en = out_en;
      case (state)
         ST_RUN: begin
            if (wr_fwd) begin
               next_out_en = 1'b0;
               next_tmr    = 32'h0;
               next_state  = ST_OFF;
            end
         end
         ST_OFF: begin
            // Lock from before the load is stale; give the PLL the disable window to drop it.
            next_tmr = tmr + 32'h1;
            if (tmr >= 32'(DISABLE_CYCLES - 1)) begin
               next_state = ST_RELOCK;
            end
         end
         ST_RELOCK: begin
            next_tmr = tmr + 32'h1;
            // The settle bound forces the output back on even if lock never reports.
            if (lock_s2 || (tmr >= 32'(SETTLE_CNT - 1))) begin
               next_out_en = 1'b1;
               next_state  = ST_RUN;
            end
         end
         default: begin
            next_state  = ST_RUN;
            next_out_en = 1'b1;
         end
      endcase
      if (wr_fwd && (state != ST_RUN)) begin
         // A restart must win over a lock seen in the same cycle, or the output would
         // run while the PLL retunes.
         next_out_en = 1'b0;
         next_tmr    = 32'h0;
         next_state  = ST_OFF;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state  <= ST_RUN;
         tmr    <= 32'h0;
         out_en <= 1'b1;
      end else begin
         state  <= next_state;
         tmr    <= next_tmr;
         out_en <= next_out_en;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // The offset word spans the full range linearly; the PLL scales by pull_range_o,
   // and a 26-bit signed word can never exceed the selected range.
   assign pull_offset_o = signed'(active_offset);
   assign pull_range_o  = range_reg[RANGE_W-1:0];
   assign pull_update_o = pull_update;
   assign synth_o       = synth;
   assign synth_load_o  = synth_load;
   assign clk_out_en_o  = out_en;
   assign soft_oe_o     = offset_high[OE_BIT];
   assign busy_o        = (state != ST_RUN);
   assign rdata_o       = rdata;
   assign rvalid_o      = rvalid;

endmodule

// >>> verification/sdp_ctrl_props.sv
// Checker of the divider control block ports.
`timescale 1ns/10ps
module sdp_ctrl_props
   import sdp_pkg::*;
#(
   parameter int SETTLE_CNT = 1000
) (
   // Watched ports
   input wire logic                core_clk_i,
   input wire logic                rst_i,
   input wire sdp_pkg::sdp_req_t   req_i,
   input wire logic [15:0]         rdata_o,
   input wire logic                rvalid_o,
   input wire logic                pll_lock_i,
   input wire sdp_pkg::sdp_synth_t synth_o,
   input wire logic                synth_load_o,
   input wire logic signed [25:0]  pull_offset_o,
   input wire logic [3:0]          pull_range_o,
   input wire logic                pull_update_o,
   input wire logic                clk_out_en_o,
   input wire logic                soft_oe_o,
   input wire logic                busy_o
);
   int unsigned busy_cnt;
   int unsigned next_busy_cnt;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wr(logic [2:0] a);
      req_i.wr && req_i.addr == a;
   endsequence
   // A relock that never ends would hide behind a level check, so count it.
   // The count starts again at each load, since a new forward write restarts the relock.
   always_comb next_busy_cnt = (busy_o && !synth_load_o) ? busy_cnt + 1 : 0;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) busy_cnt <= 0;
      else busy_cnt <= next_busy_cnt;
   end
   a_relock_start: assert property (s_wr(ADDR_FWD_DRIVE) |=> synth_load_o && busy_o
      && !clk_out_en_o) else $error("relock did not start");
   a_output_off: assert property (synth_load_o |-> !clk_out_en_o [*8])
      else $error("output enabled too early");
   a_settle_bound: assert property (busy_cnt <= SETTLE_CNT + 2)
      else $error("relock too long");
   a_fwd_decode: assert property (s_wr(ADDR_FWD_DRIVE) |=> synth_o.drive[5:3] ==
      $past(req_i.wdata[2:0]) && synth_o.forward == ($past(req_i.wdata[15:3]) ^ FWD_MASK))
      else $error("forward divider decode wrong");
   a_int_decode: assert property (s_wr(ADDR_FB_INT_FRAC) |=> synth_o.feedback[31:16] ==
      {$past(req_i.wdata[15:11]) ^ FB_INT_MASK, $past(req_i.wdata[10:0])})
      else $error("feedback decode wrong");
   a_drive_low: assert property (s_wr(ADDR_DRIVE_MISC) |=>
      synth_o.drive[2:0] == $past(req_i.wdata[2:0])) else $error("drive low wrong");
   a_high_commit: assert property (s_wr(ADDR_OFFSET_HIGH) |=> pull_update_o &&
      pull_offset_o[25:16] == $past(req_i.wdata[9:0])) else $error("offset not committed");
   a_low_held: assert property (s_wr(ADDR_OFFSET_LOW) |=> $stable(pull_offset_o))
      else $error("low word took effect");
   a_update_cause: assert property (pull_update_o |->
      $past(req_i.wr && req_i.addr == ADDR_OFFSET_HIGH)) else $error("stray update");
   a_range_write: assert property (s_wr(ADDR_PULL_RANGE) |=>
      pull_range_o == $past(req_i.wdata[3:0])) else $error("range not stored");
   a_read_answer: assert property (req_i.rd |=> rvalid_o)
      else $error("read not answered");
endmodule

bind sdp_ctrl sdp_ctrl_props #(.SETTLE_CNT(SETTLE_CNT)) u_props (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
   .rvalid_o(rvalid_o), .pll_lock_i(pll_lock_i), .synth_o(synth_o),
   .synth_load_o(synth_load_o), .pull_offset_o(pull_offset_o),
   .pull_range_o(pull_range_o), .pull_update_o(pull_update_o),
   .clk_out_en_o(clk_out_en_o), .soft_oe_o(soft_oe_o), .busy_o(busy_o)
);

// >>> verification/sdp_host.sv
// Host model that reaches the control registers one word at a time.
`timescale 1ns/10ps
module sdp_host
   import sdp_pkg::*;
(
   // Clock and answer
   input  wire logic         core_clk_i,
   input  wire logic [15:0]  rdata_i,
   // Requests
   output sdp_pkg::sdp_req_t req_o
);
   initial req_o = '0;
   // Each strobe lasts one cycle and a free cycle follows, so calls never collide.
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk_i);
      #1 req_o.wr = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge core_clk_i);
      #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge core_clk_i);
      #1 req_o.rd = 1'b0;
      d = rdata_i;
   endtask
   task automatic prog(input logic [4:0] ni, input logic [26:0] nf, input logic [12:0] m,
                       input logic [5:0] dv);
      logic [15:0] r6;
      rd(ADDR_DRIVE_MISC, r6);
      wr(ADDR_FB_INT_FRAC, {ni ^ FB_INT_MASK, nf[26:16]});
      wr(ADDR_FB_FRAC_LOW, nf[15:0]);
      wr(ADDR_DRIVE_MISC, {r6[15:3], dv[2:0]});
      wr(ADDR_FWD_DRIVE, {m ^ FWD_MASK, dv[5:3]});
   endtask
   task automatic pull(input logic [25:0] v, input logic oe);
      wr(ADDR_OFFSET_LOW, v[15:0]);
      wr(ADDR_OFFSET_HIGH, {5'h00, oe, v[25:16]});
   endtask
endmodule

// >>> verification/test_sdp_ctrl.sv
// Self-checking bench of the divider control block.
`timescale 1ns/10ps
module test_sdp_ctrl;
   import sdp_pkg::*;
   localparam int SETTLE = 1000;
   logic               core_clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic               pll_lock_i = 1'b0;
   sdp_req_t           req;
   sdp_synth_t         synth;
   logic [15:0]        rdata;
   logic [15:0]        r;
   logic signed [25:0] offset;
   logic [3:0]         range;
   logic               rvalid, load, upd, en, soe, busy;
   int                 err_total = 0;
   int                 checked = 0;
   always #2 core_clk_i = ~core_clk_i;
   sdp_ctrl #(.SETTLE_CNT(SETTLE)) u_dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
      .rvalid_o(rvalid), .pll_lock_i(pll_lock_i), .synth_o(synth), .synth_load_o(load),
      .pull_offset_o(offset), .pull_range_o(range), .pull_update_o(upd),
      .clk_out_en_o(en), .soft_oe_o(soe), .busy_o(busy));
   sdp_host u_host (.core_clk_i(core_clk_i), .rdata_i(rdata), .req_o(req));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (err_total == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_en(input int n);
      int i;
      i = 0;
      while (en !== 1'b1 && i < n) begin
         @(posedge core_clk_i);
         #1 i++;
      end
      if (i >= n) begin
         err_total++;
         $display("[ERR] %0t output enable timeout", $time);
         summarize();
      end
   endtask
   task automatic t_reset();
      chk(en, 1);
      chk({offset}, 0);
      chk(range, FACTORY_RANGE);
      chk(synth.feedback, 32'h70000000);
      chk(synth.forward, 13'h001B);
      u_host.rd(ADDR_OFFSET_HIGH, r);
      chk(r, 16'h0000);
   endtask
   // 75 MHz example: N = 13.56383, M = 17, drive for the high-swing output.
   task automatic t_program();
      u_host.wr(ADDR_DRIVE_MISC, 16'hABC0);
      u_host.prog(5'h0D, 27'h482B94E, 13'h0011, 6'h36);
      chk(busy, 1);
      chk(load, 1);
      chk(en, 0);
      chk(synth.feedback, 32'h6C82B94E);
      chk(synth.forward, 13'h0011);
      chk(synth.drive, 6'h36);
      u_host.rd(ADDR_DRIVE_MISC, r);
      chk(r, 16'hABC6);
      chk(rvalid, 1);
      repeat (600) @(posedge core_clk_i);
      #1 chk(en, 0);
      pll_lock_i = 1'b1;
      wait_en(10);
      chk(busy, 0);
      pll_lock_i = 1'b0;
      u_host.wr(ADDR_FWD_DRIVE, 16'h0056);
      repeat (SETTLE - 10) @(posedge core_clk_i);
      #1 chk(en, 0);
      wait_en(30);
   endtask
   // A second forward write lands on the last cycle of the disable window, one cycle before the stale lock would re-enable the output.
   task automatic t_restart();
      u_host.wr(ADDR_FWD_DRIVE, 16'h0056);
      pll_lock_i = 1'b1;
      repeat (DISABLE_CYCLES - 2) @(posedge core_clk_i);
      u_host.wr(ADDR_FWD_DRIVE, 16'h0056);
      chk(en, 0);
      chk(busy, 1);
      repeat (DISABLE_CYCLES - 10) @(posedge core_clk_i);
      #1 chk(en, 0);
      wait_en(20);
      chk(busy, 0);
      pll_lock_i = 1'b0;
   endtask
   task automatic t_pull();
      u_host.wr(ADDR_OFFSET_LOW, 16'h6666);
      chk({offset}, 0);
      u_host.pull(26'h0E66666, 1'b1);
      chk(upd, 1);
      chk({offset}, 32'h00E66666);
      chk(soe, 1);
      repeat (6600) @(posedge core_clk_i);
      u_host.pull(26'h3800000, 1'b1);
      chk({offset}, 32'h03800000);
      u_host.wr(ADDR_PULL_RANGE, 16'hFFFF);
      chk(range, 4'hF);
      u_host.rd(ADDR_PULL_RANGE, r);
      chk(r, 16'h000F);
      u_host.wr(3'h7, 16'h1234);
      u_host.rd(3'h7, r);
      chk(r, 16'h0000);
   endtask
   initial begin
      repeat (2) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      t_reset();
      t_program();
      t_restart();
      t_pull();
      summarize();
   end
endmodule
